// file: rtl/timc_itb.sv
/*
  Interrupt time base generator: high phase then low phase, lengths
  in 84.175 us units. Assumes the code input is from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module timc_itb
  import timc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] itb_code,
  output logic irq_level
);

  logic [ITB_PRE_W-1:0] pre_r;
  logic half_r;
  logic [ITB_UNITS_W-1:0] unit_r;
  logic level_r;
  timc_itb_s cur_r;
  logic unit_end;
  logic phase_end;
  logic [ITB_PRE_W-1:0] pre_lim;

  // Units alternate 1683 and 1684 cycles to average 1683.5
  assign pre_lim = half_r ? ITB_PRE_W'(ITB_UNIT_B_CYC - 1)
                          : ITB_PRE_W'(ITB_UNIT_A_CYC - 1);
  assign unit_end = (pre_r == pre_lim);
  assign phase_end = unit_end &&
    (unit_r == (level_r ? cur_r.high_units : cur_r.low_units) - 4'h1);

  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_r <= '0;
      half_r <= 1'b0;
      unit_r <= '0;
      level_r <= 1'b1;
      cur_r <= '{high_units: 4'h3, low_units: 4'h3};
    end else begin
      pre_r <= unit_end ? '0 : pre_r + 1'b1;
      if (unit_end) begin
        half_r <= ~half_r;
        unit_r <= phase_end ? '0 : unit_r + 1'b1;
      end
      if (phase_end) begin
        level_r <= ~level_r;
        if (!level_r) begin
          cur_r <= timc_itb_decode(itb_code);
        end
      end
    end
  end

  assign irq_level = level_r;

endmodule // timc_itb

`default_nettype wire

// file: rtl/timc_sync.sv
/*
  Two-stage synchroniser for a bundle of asynchronous pins.
  Assumes the bundle may be sampled bit by bit.
*/
`timescale 1ns/1ps
`default_nettype none

module timc_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule // timc_sync

`default_nettype wire

// file: rtl/timc_top.sv
/*
  Timing control register of the correlator with the tick generator,
  interrupt output gating, status latch strobe, marker pin selection
  and feedback pulse width measurement it steers.
  Assumes host bus, companion chip and feedback pins are asynchronous;
  time_mark and ch1_dump_evt come from logic on mclk.
*/
//
// Function
// - Tick every 571428 timing clocks when low
// - Tick every 51948 timing clocks when high
// - Reset clears every control field to zero
// - Enable low holds pin low, no sampling
// - Enable high drives interrupt, samples status
// - Origin picks internal or companion tick
// - Own interrupt edge latches status, style-dependent
// - Origin high uses companion interrupt edge
// - Marker pin: time mark or test signal
// - Feedback field picks input 1-3 or tick
// - Measure width between selected signal edges
// - Oscillator check square wave, 4.55 us
// - Channel-1 dump toggles marker pin level
// - Time base field selects interrupt period
// - Periods 420.875 to 1346.8 us, default 505.05
// - After reset: 100 ms tick, irq low
`timescale 1ns/1ps
`default_nettype none

module timc_top
  import timc_pkg::*;
#(
  parameter int unsigned TICK_LONG_CYCLES = TICK_LONG_CYC,
  parameter int unsigned TICK_SHORT_CYCLES = TICK_SHORT_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic host_cs_n,
  input wire logic host_wr_n,
  input wire logic [HOST_ADDR_W-1:0] host_addr,
  input wire logic [HOST_DATA_W-1:0] host_data,
  input wire logic bus_style_falling,
  input wire logic tick_input_pin,
  input wire logic irq_input_pin,
  input wire logic feedback_input_1,
  input wire logic feedback_input_2,
  input wire logic feedback_input_3,
  input wire logic time_mark,
  input wire logic ch1_dump_evt,
  output logic measurement_tick,
  output logic tick_output_pin,
  output logic irq_output_pin,
  output logic status_latch,
  output logic marker_pin,
  output logic [FB_WIDTH_W-1:0] fb_width,
  output logic fb_width_valid
);

  localparam int AD_W = HOST_ADDR_W + HOST_DATA_W;
  localparam int BUS_W = 2 + AD_W;

  // Clock and reset of every check in this module
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Pin synchronisers
  logic [BUS_W-1:0] bus_q;
  logic [5:0] pin_q;

  timc_sync #(.W(BUS_W)) u_bus_sync (
    .mclk(mclk),
    .rst(rst),
    .d({host_cs_n, host_wr_n, host_addr, host_data}),
    .q(bus_q)
  );

  timc_sync #(.W(6)) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .d({bus_style_falling, tick_input_pin, irq_input_pin,
        feedback_input_3, feedback_input_2, feedback_input_1}),
    .q(pin_q)
  );

  // Host write: captured on the trailing edge of the strobe
  logic [AD_W-1:0] bus_d_r;
  timc_ctrl_s ctrl_r;
  logic wr_act;
  logic wr_act_d_r;
  logic wr_end;
  logic wr_hit;

  // Strobes are combined only after both have passed the synchroniser
  assign wr_act = !bus_q[BUS_W-1] && !bus_q[BUS_W-2];
  assign wr_end = wr_act_d_r && !wr_act;
  assign wr_hit = wr_end &&
    (bus_d_r[HOST_DATA_W +: HOST_ADDR_W] == TIMING_CONTROL_ADDR);

  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_d_r <= '0;
      wr_act_d_r <= 1'b0;
      ctrl_r <= timc_ctrl_s'(TIMING_CONTROL_RESET);
    end else begin
      bus_d_r <= bus_q[AD_W-1:0];
      wr_act_d_r <= wr_act;
      if (wr_hit) begin
        ctrl_r <= timc_ctrl_s'(bus_d_r[HOST_DATA_W-1:0]);
      end
    end
  end

  // Edge detection on synchronised pins
  logic [5:0] pin_d_r;
  logic style_fall;
  logic ext_tick_edge;
  logic ext_irq_edge;

  assign style_fall = pin_q[5];
  assign ext_tick_edge = pin_q[4] && !pin_d_r[4];
  assign ext_irq_edge = style_fall ? (!pin_q[3] && pin_d_r[3])
                                   : (pin_q[3] && !pin_d_r[3]);

  // Internal tick generator, free running
  logic [TICK_CNT_W-1:0] tick_cnt_r;
  logic [TICK_CNT_W-1:0] tick_lim_m1;
  logic tick_int;
  logic tick_sel;

  assign tick_lim_m1 = ctrl_r.tick_interval_select
    ? TICK_CNT_W'(TICK_SHORT_CYCLES - 1)
    : TICK_CNT_W'(TICK_LONG_CYCLES - 1);
  assign tick_int = (tick_cnt_r >= tick_lim_m1);
  assign tick_sel = ctrl_r.tick_origin_select ? ext_tick_edge
                                              : tick_int;

  // Interrupt time base and status latch strobe
  logic itb_level;
  logic itb_d_r;
  logic own_irq_edge;
  logic irq_edge;

  timc_itb u_itb (
    .mclk(mclk),
    .rst(rst),
    .itb_code(ctrl_r.itb_code),
    .irq_level(itb_level)
  );

  assign own_irq_edge = style_fall ? (!itb_level && itb_d_r)
                                   : (itb_level && !itb_d_r);
  assign irq_edge = ctrl_r.irq_origin_select ? ext_irq_edge
                                             : own_irq_edge;

  // Marker pin sources
  logic [OSC_CNT_W-1:0] osc_cnt_r;
  logic osc_level_r;
  logic dump_tog_r;
  logic marker_nxt;
  logic osc_end;

  assign osc_end = (osc_cnt_r == OSC_CNT_W'(OSC_PERIOD_CYC - 1));
  assign marker_nxt = !ctrl_r.marker_test_select ? time_mark
    : (ctrl_r.marker_test_source ? dump_tog_r : osc_level_r);

  // Feedback pulse width measurement
  logic fb_sig;
  logic fb_sig_d_r;
  logic fb_rise;
  logic fb_fall;
  logic fb_start;
  logic fb_stop;
  logic fb_busy_r;
  logic [FB_WIDTH_W-1:0] fb_cnt_r;

  assign fb_sig = (ctrl_r.fb_edge_sel[2:1] == 2'h0) ? pin_q[0]
    : (ctrl_r.fb_edge_sel[2:1] == 2'h1) ? pin_q[1]
    : (ctrl_r.fb_edge_sel[2:1] == 2'h2) ? pin_q[2]
    : tick_output_pin;
  assign fb_rise = fb_sig && !fb_sig_d_r;
  assign fb_fall = !fb_sig && fb_sig_d_r;
  assign fb_start = ctrl_r.fb_edge_sel[0] ? fb_fall : fb_rise;
  assign fb_stop = ctrl_r.fb_edge_sel[0] ? fb_rise : fb_fall;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_d_r <= '0;
      tick_cnt_r <= '0;
      // Matches the time base reset level, so no false edge follows reset
      itb_d_r <= 1'b1;
      measurement_tick <= 1'b0;
      tick_output_pin <= 1'b0;
      irq_output_pin <= 1'b0;
      status_latch <= 1'b0;
    end else begin
      pin_d_r <= pin_q;
      tick_cnt_r <= tick_int ? '0 : tick_cnt_r + 1'b1;
      itb_d_r <= itb_level;
      measurement_tick <= tick_sel;
      tick_output_pin <= tick_sel;
      irq_output_pin <= ctrl_r.irq_output_enable && itb_level;
      status_latch <= ctrl_r.irq_output_enable && irq_edge;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      osc_cnt_r <= '0;
      osc_level_r <= 1'b1;
      dump_tog_r <= 1'b0;
      marker_pin <= 1'b0;
    end else begin
      osc_cnt_r <= osc_end ? '0 : osc_cnt_r + 1'b1;
      osc_level_r <= (osc_end || osc_cnt_r < OSC_CNT_W'(OSC_HIGH_CYC - 1));
      if (ch1_dump_evt) begin
        dump_tog_r <= ~dump_tog_r;
      end
      marker_pin <= marker_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fb_sig_d_r <= 1'b0;
      fb_busy_r <= 1'b0;
      fb_cnt_r <= '0;
      fb_width <= '0;
      fb_width_valid <= 1'b0;
    end else begin
      fb_sig_d_r <= fb_sig;
      fb_width_valid <= fb_busy_r && fb_stop;
      if (fb_start) begin
        fb_busy_r <= 1'b1;
        fb_cnt_r <= FB_WIDTH_W'(1);
      end else if (fb_busy_r && fb_stop) begin
        fb_busy_r <= 1'b0;
        fb_width <= fb_cnt_r;
      end else if (fb_busy_r && !(&fb_cnt_r)) begin
        fb_cnt_r <= fb_cnt_r + 1'b1;
      end
    end
  end

  // Checks
  property p_reset_clear;
    $past(rst) |-> (ctrl_r == timc_ctrl_s'(16'h0000) && !irq_output_pin);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("control register not cleared by reset");

  property p_tick_limit;
    tick_int && $stable(ctrl_r.tick_interval_select) |->
      tick_cnt_r == (ctrl_r.tick_interval_select
        ? TICK_CNT_W'(TICK_SHORT_CYCLES - 1)
        : TICK_CNT_W'(TICK_LONG_CYCLES - 1)) ##1 tick_cnt_r == '0;
  endproperty
  a_tick_limit: assert property (p_tick_limit)
    else $error("internal tick at wrong count");

  property p_irq_low;
    !ctrl_r.irq_output_enable ##1 1'b1 |->
      !irq_output_pin && !status_latch;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt pin or latch active while disabled");

  property p_irq_follow;
    ctrl_r.irq_output_enable |=> irq_output_pin == $past(itb_level);
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("interrupt pin does not follow time base");

  property p_tick_origin;
    ctrl_r.tick_origin_select && ext_tick_edge |=> tick_output_pin;
  endproperty
  a_tick_origin: assert property (p_tick_origin)
    else $error("companion tick not forwarded");

  property p_own_latch;
    ctrl_r.irq_output_enable && !ctrl_r.irq_origin_select &&
      own_irq_edge |=> status_latch;
  endproperty
  a_own_latch: assert property (p_own_latch)
    else $error("own interrupt edge did not latch status");

  property p_ext_latch;
    ctrl_r.irq_output_enable && ctrl_r.irq_origin_select &&
      !ext_irq_edge |=> !status_latch;
  endproperty
  a_ext_latch: assert property (p_ext_latch)
    else $error("status latched without companion edge");

  property p_marker_mark;
    !ctrl_r.marker_test_select |=> marker_pin == $past(time_mark);
  endproperty
  a_marker_mark: assert property (p_marker_mark)
    else $error("marker pin does not carry time mark");

  property p_osc_period;
    osc_end |=> osc_level_r ##(OSC_HIGH_CYC) !osc_level_r
      ##(OSC_PERIOD_CYC - OSC_HIGH_CYC) osc_level_r;
  endproperty
  a_osc_period: assert property (p_osc_period)
    else $error("oscillator check period wrong");

  property p_dump_toggle;
    ch1_dump_evt |=> dump_tog_r != $past(dump_tog_r);
  endproperty
  a_dump_toggle: assert property (p_dump_toggle)
    else $error("dump event did not toggle marker source");

endmodule // timc_top

`default_nettype wire

// file: shared/timc_pkg.sv
/*
  Constants, field layout and decode function for the timing control
  block of the correlator. Assumes a 20 MHz master clock.
*/
`default_nettype none

package timc_pkg;

  // Master clock
  localparam int CLK_NS = 50;

  // Host bus
  localparam int HOST_ADDR_W = 8;
  localparam int HOST_DATA_W = 16;
  localparam logic [7:0] TIMING_CONTROL_ADDR = 8'hC2;
  localparam logic [15:0] TIMING_CONTROL_RESET = 16'h0000;

  // Measurement tick: periods of the 175 ns timing clock
  localparam int TICK_UNIT_NS = 175;
  localparam int TICK_LONG_UNITS = 571428;
  localparam int TICK_SHORT_UNITS = 51948;
  localparam int TICK_LONG_CYC = (TICK_LONG_UNITS * TICK_UNIT_NS) / CLK_NS;
  localparam int TICK_SHORT_CYC = (TICK_SHORT_UNITS * TICK_UNIT_NS) / CLK_NS;
  localparam int TICK_CNT_W = 21;

  // Oscillator check: 40 MHz reference divided by 182
  localparam int REF_CLK_NS = 25;
  localparam int OSC_DIV = 182;
  localparam int OSC_PERIOD_NS = REF_CLK_NS * OSC_DIV;
  localparam int OSC_PERIOD_CYC = OSC_PERIOD_NS / CLK_NS;
  localparam int OSC_HIGH_CYC = OSC_PERIOD_CYC / 2;
  localparam int OSC_CNT_W = 7;

  // Interrupt time base: all times are multiples of 84.175 us
  localparam int ITB_UNIT_NS = 84175;
  localparam int ITB_PAIR_CYC = (2 * ITB_UNIT_NS) / CLK_NS;
  localparam int ITB_UNIT_A_CYC = ITB_PAIR_CYC / 2;
  localparam int ITB_UNIT_B_CYC = ITB_PAIR_CYC - ITB_UNIT_A_CYC;
  localparam int ITB_PRE_W = 11;
  localparam int ITB_UNITS_W = 4;

  // Feedback pulse width counter
  localparam int FB_WIDTH_W = 16;

  typedef struct packed {
    logic [2:0] unused_hi;
    logic [3:0] itb_code;
    logic marker_test_source;
    logic [2:0] fb_edge_sel;
    logic marker_test_select;
    logic irq_origin_select;
    logic tick_origin_select;
    logic irq_output_enable;
    logic tick_interval_select;
  } timc_ctrl_s;

  typedef struct packed {
    logic [3:0] high_units;
    logic [3:0] low_units;
  } timc_itb_s;

  // High and low times of the interrupt period, in 84.175 us units
  function automatic timc_itb_s timc_itb_decode(input logic [3:0] code);
    timc_itb_s t;
    t = '{high_units: 4'h3, low_units: 4'h3};
    unique case (code)
      4'h4: t = '{high_units: 4'h1, low_units: 4'h4};
      4'h5: t = '{high_units: 4'h3, low_units: 4'h3};
      4'h6: t = '{high_units: 4'h4, low_units: 4'h3};
      4'h7: t = '{high_units: 4'h4, low_units: 4'h4};
      4'h8: t = '{high_units: 4'h5, low_units: 4'h4};
      4'h9: t = '{high_units: 4'h5, low_units: 4'h5};
      4'hA: t = '{high_units: 4'h6, low_units: 4'h5};
      4'hB: t = '{high_units: 4'h1, low_units: 4'hB};
      4'hC: t = '{high_units: 4'h2, low_units: 4'hB};
      4'hD: t = '{high_units: 4'h1, low_units: 4'hD};
      4'hE: t = '{high_units: 4'h2, low_units: 4'hD};
      4'hF: t = '{high_units: 4'h5, low_units: 4'hB};
      default: t = '{high_units: 4'h3, low_units: 4'h3};
    endcase
    return t;
  endfunction

endpackage

`default_nettype wire

// file: tb/timc_host_model.sv
/*
  Host microprocessor model: write cycles to the timing control block.
  Assumes the block samples the bus on mclk and the bus is write only.
*/
`timescale 1ns/1ps
`default_nettype none

module timc_host_model
  import timc_pkg::*;
(
  input wire logic mclk,
  output var logic host_cs_n,
  output var logic host_wr_n,
  output var logic [HOST_ADDR_W-1:0] host_addr,
  output var logic [HOST_DATA_W-1:0] host_data
);
  initial begin
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    host_addr = 8'h00;
    host_data = 16'hFFFF;
  end

  // Returns once the written value is in effect
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    host_addr = a;
    host_data = d;
    host_cs_n = 1'b0;
    host_wr_n = 1'b0;
    repeat (4) @(negedge mclk);
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    repeat (2) @(negedge mclk);
    // A released bus must not keep showing the old value
    host_addr = ~a;
    host_data = ~d;
    repeat (4) @(negedge mclk);
  endtask
endmodule // timc_host_model

`default_nettype wire

// file: tb/timc_top_tb_top.sv
/*
  Self-checking testbench of the timing control block.
  Assumes short tick parameters and a host model on the bus.
*/
`timescale 1ns/1ps
`default_nettype none

module timc_top_tb_top
  import timc_pkg::*;
;
  localparam int TL = 40;
  localparam int TS = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, wr_n, tick_in, irq_in, time_mark, dump, style;
  logic [7:0] addr;
  logic [15:0] data;
  logic [2:0] fbp;
  logic tick, tick_pin, irq_pin, latch, marker, fb_valid;
  logic [15:0] fb_width;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  wire logic [5:0] mon = {fb_valid, marker, latch, irq_pin, tick_pin, tick};

  always #25 mclk = ~mclk;

  timc_host_model i_timc_host_model (.mclk(mclk), .host_cs_n(cs_n),
    .host_wr_n(wr_n), .host_addr(addr), .host_data(data));

  timc_top #(.TICK_LONG_CYCLES(TL), .TICK_SHORT_CYCLES(TS)) i_timc_top (
    .mclk(mclk), .rst(rst), .host_cs_n(cs_n), .host_wr_n(wr_n),
    .host_addr(addr), .host_data(data), .bus_style_falling(style),
    .tick_input_pin(tick_in), .irq_input_pin(irq_in),
    .feedback_input_1(fbp[0]), .feedback_input_2(fbp[1]),
    .feedback_input_3(fbp[2]), .time_mark(time_mark),
    .ch1_dump_evt(dump), .measurement_tick(tick),
    .tick_output_pin(tick_pin), .irq_output_pin(irq_pin),
    .status_latch(latch), .marker_pin(marker), .fb_width(fb_width),
    .fb_width_valid(fb_valid));

  task automatic results;
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Counts falling edges until a masked output reaches level p
  task automatic wt(input logic [5:0] m, input logic p, input int lim,
                    output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((|(mon & m)) !== p && n < lim);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_timc_host_model.write(a, d);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      results();
    end
  end

  task automatic t_reset;
    chk({10'h000, mon}, 16'h0000);
    chk(fb_width, 16'h0000);
  endtask

  task automatic t_tick;
    int n;
    wt(6'h01, 1'b1, TL + 5, n);
    wt(6'h01, 1'b1, TL + 5, n);
    chk(16'(n), 16'(TL));
    chk({15'h0000, mon[1]}, 16'h0001);
    wr(8'hC2, 16'h0001);
    wt(6'h01, 1'b1, TL + 5, n);
    wt(6'h01, 1'b1, TL + 5, n);
    chk(16'(n), 16'(TS));
  endtask

  task automatic t_ext;
    int n;
    wr(8'hC2, 16'h0004);
    wt(6'h01, 1'b1, 50, n);
    chk(16'(n), 16'h0032);
    wr(8'hC3, 16'h0000);
    wt(6'h01, 1'b1, 50, n);
    chk(16'(n), 16'h0032);
    tick_in = 1'b1;
    wt(6'h01, 1'b1, 8, n);
    chk(16'(n <= 5), 16'h0001);
    tick_in = 1'b0;
  endtask

  task automatic t_irq;
    int n;
    wt(6'h0C, 1'b1, 12000, n);
    chk({14'h0000, mon[3:2]}, 16'h0000);
    wr(8'hC2, 16'h0002);
    wt(6'h08, 1'b1, 12000, n);
    chk({15'h0000, mon[2]}, 16'h0001);
    wt(6'h08, 1'b1, 12000, n);
    chk(16'(n), 16'(10101));
    wr(8'hC2, 16'h1602);
    wt(6'h08, 1'b1, 12000, n);
    wt(6'h08, 1'b1, 21000, n);
    chk(16'(n), 16'(20202));
    wr(8'hC2, 16'h000A);
    irq_in = 1'b1;
    wt(6'h08, 1'b1, 8, n);
    chk(16'(n <= 6), 16'h0001);
    irq_in = 1'b0;
    wr(8'hC2, 16'h0008);
    irq_in = 1'b1;
    wt(6'h0C, 1'b1, 20, n);
    chk(16'(n), 16'h0014);
    irq_in = 1'b0;
    style = 1'b1;
    wr(8'hC2, 16'h0002);
    wt(6'h08, 1'b1, 21000, n);
    chk({15'h0000, mon[2]}, 16'h0000);
    style = 1'b0;
  endtask

  task automatic t_marker;
    int n;
    logic m;
    time_mark = 1'b1;
    repeat (2) @(negedge mclk);
    chk({15'h0000, marker}, 16'h0001);
    time_mark = 1'b0;
    wr(8'hC2, 16'h0010);
    wt(6'h10, 1'b0, 100, n);
    wt(6'h10, 1'b1, 100, n);
    wt(6'h10, 1'b0, 100, n);
    chk(16'(n), 16'h002D);
    wt(6'h10, 1'b1, 100, n);
    chk(16'(n), 16'h002E);
    wr(8'hC2, 16'h0110);
    m = marker;
    dump = 1'b1;
    @(negedge mclk);
    dump = 1'b0;
    repeat (2) @(negedge mclk);
    chk({15'h0000, marker}, {15'h0000, ~m});
  endtask

  task automatic t_fb;
    int n;
    for (int k = 0; k < 6; k++) begin
      fbp = {3{k[0]}};
      wr(8'hC2, 16'(k << 5));
      fbp[k >> 1] = ~k[0];
      repeat (10 + k) @(negedge mclk);
      fbp[k >> 1] = k[0];
      wt(6'h20, 1'b1, 10, n);
      chk(fb_width, 16'(10 + k));
    end
    fbp = 3'h0;
    wr(8'hC2, 16'h00C0);
    wt(6'h20, 1'b1, 50, n);
    chk(fb_width, 16'h0001);
    wr(8'hC2, 16'h00E0);
    wt(6'h20, 1'b1, 100, n);
    chk(fb_width, 16'(TL - 1));
  endtask

  initial begin
    tick_in = 1'b0;
    irq_in = 1'b0;
    time_mark = 1'b0;
    dump = 1'b0;
    style = 1'b0;
    fbp = 3'h0;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_tick();
    t_ext();
    t_irq();
    t_marker();
    t_fb();
    results();
  end
endmodule // timc_top_tb_top

`default_nettype wire
